// [hw/ipic_channel.sv]
// input pulse interval capture channel with apb register slave
// assumes apb master on clk_sys; timer input pin is asynchronous
module ipic_channel
    import ipic_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_input_pin,
    output logic             channel_interrupt
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ipic_state_type     st;
        logic               unit_en;
        logic               filter_en;
        logic [5:0]         mode;
        logic [15:0]        cnt;
        logic [15:0]        cap;
        logic               wrap_flag;
        logic               wrap_seen;
        logic               irq;
        logic [31:0]        rdata;
        logic               slverr;
        logic               ready;
    } ipic_state_struct_type;

    ipic_state_struct_type s_q;
    ipic_state_struct_type s_d;
    logic                  wr;
    logic                  rd;
    logic                  start_trig;
    logic                  stop_trig;
    logic                  running;
    logic                  pin_edge;
    logic                  capture;
    logic                  mapped;
    logic                  unit_clr;

    ipic_edge_detect u_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .clr        (unit_clr),
        .pin        (timer_input_pin),
        .filter_en  (s_q.filter_en),
        .edge_sel   ({s_q.mode[MODE_EDGE_HI], s_q.mode[MODE_EDGE_LO]}),
        .valid_edge (pin_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d        = s_q;
        // one-wait apb: response registered, answer one cycle after the access cycle
        wr         = psel & penable & pwrite & ~s_q.ready;
        rd         = psel & penable & ~pwrite & ~s_q.ready;
        mapped     = (paddr[7:5] == 3'b000) && (paddr[1:0] == 2'b00);
        unit_clr   = ~s_q.unit_en;
        // triggers are pulses, never stored: reads as 0
        start_trig = wr && s_q.unit_en && paddr == ADDR_START_TRIG && pwdata[0];
        stop_trig  = wr && s_q.unit_en && paddr == ADDR_STOP_TRIG && pwdata[0];
        running    = (s_q.st != IPIC_IDLE);
        capture    = (s_q.st == IPIC_COUNT) && (pin_edge || start_trig);
        s_d.irq    = 1'b0;
        s_d.ready  = psel & penable & ~s_q.ready;
        s_d.slverr = psel & penable & ~s_q.ready & ~mapped;
        s_d.rdata  = RDATA_RESET;

        case (s_q.st)
            IPIC_IDLE: begin
                if (start_trig) begin
                    s_d.st  = IPIC_LOAD;
                    s_d.irq = s_q.mode[MODE_START_IRQ];
                end
            end
            IPIC_LOAD: begin
                s_d.cnt       = COUNT_RESET;
                s_d.wrap_seen = 1'b0;
                s_d.st        = IPIC_COUNT;
            end
            IPIC_COUNT: begin
                if (capture) begin
                    s_d.cap       = s_q.cnt;
                    s_d.cnt       = COUNT_RESET;
                    s_d.irq       = 1'b1;
                    s_d.wrap_flag = s_q.wrap_seen | (s_q.cnt == COUNT_MAX);
                    s_d.wrap_seen = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                    if (s_q.cnt == COUNT_MAX) begin
                        s_d.wrap_seen = 1'b1;
                    end
                end
            end
            default: s_d.st = IPIC_IDLE;
        endcase

        if (stop_trig && running) begin
            s_d.st  = IPIC_IDLE;
            s_d.cnt = s_q.cnt;
            s_d.cap = s_q.cap;
            s_d.wrap_flag = s_q.wrap_flag;
            s_d.irq = 1'b0;
        end

        if (wr && paddr == ADDR_UNIT_CTRL) begin
            s_d.unit_en = pwdata[UNIT_CLK_EN];
            if (s_q.unit_en) begin
                s_d.filter_en = pwdata[FILTER_EN];
            end
        end
        if (wr && s_q.unit_en && paddr == ADDR_MODE_CFG) begin
            // while running only the edge bits take a write
            if (running) begin
                s_d.mode[MODE_EDGE_HI] = pwdata[MODE_EDGE_HI];
                s_d.mode[MODE_EDGE_LO] = pwdata[MODE_EDGE_LO];
            end else begin
                s_d.mode = pwdata[MODE_WIDTH-1:0];
            end
        end

        if (rd) begin
            case (paddr)
                ADDR_ENABLE_STAT: s_d.rdata = {31'h0000_0000, running};
                ADDR_MODE_CFG:    s_d.rdata = {26'h000_0000, s_q.mode};
                ADDR_COUNTER:     s_d.rdata = {16'h0000, s_q.cnt};
                ADDR_CAPTURE:     s_d.rdata = {16'h0000, s_q.cap};
                ADDR_STATUS:      s_d.rdata = {31'h0000_0000, s_q.wrap_flag};
                ADDR_UNIT_CTRL:   s_d.rdata = {30'h0000_0000, s_q.filter_en, s_q.unit_en};
                default:          s_d.rdata = RDATA_RESET;
            endcase
        end

        // unit off: every channel register except the apb response back to its initial value
        if (~s_q.unit_en && ~(wr && paddr == ADDR_UNIT_CTRL && pwdata[UNIT_CLK_EN])) begin
            s_d.st        = IPIC_IDLE;
            s_d.filter_en = 1'b0;
            s_d.mode      = MODE_RESET;
            s_d.cnt       = COUNT_RESET;
            s_d.cap       = COUNT_RESET;
            s_d.wrap_flag = 1'b0;
            s_d.wrap_seen = 1'b0;
            s_d.irq       = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata            = s_q.rdata;
    assign pready            = s_q.ready;
    assign pslverr           = s_q.slverr;
    assign channel_interrupt = s_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    AST_START_LOADS: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == IPIC_IDLE && start_trig) |=> ##1 (s_q.cnt == COUNT_RESET))
        else $error("counter not cleared after start");
    AST_START_ENABLE: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == IPIC_IDLE && start_trig) |=> (s_q.st != IPIC_IDLE))
        else $error("start did not enable channel");
    AST_START_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == IPIC_IDLE && start_trig)
        |=> (channel_interrupt == $past(s_q.mode[MODE_START_IRQ])))
        else $error("start interrupt wrong");
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
        (capture && !stop_trig) |=> (s_q.cap == $past(s_q.cnt)))
        else $error("capture value wrong");
    AST_CAP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (capture && !stop_trig && s_q.unit_en) |=> (s_q.cnt == COUNT_RESET && channel_interrupt))
        else $error("capture did not clear counter or pulse interrupt");
    AST_WRAP_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
        (capture && !stop_trig && !s_q.wrap_seen && s_q.cnt != COUNT_MAX) |=> !s_q.wrap_flag)
        else $error("wrap flag not cleared");
    AST_WRAP_SEEN: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == IPIC_COUNT && !capture && !stop_trig && s_q.unit_en && s_q.cnt == COUNT_MAX)
        |=> (s_q.cnt == COUNT_RESET && s_q.wrap_seen))
        else $error("wrap not latched");
    AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.st == IPIC_IDLE && s_q.unit_en && !start_trig) |=> $stable(s_q.cnt))
        else $error("counter moved while stopped");
    AST_STOP: assert property (@(posedge clk_sys) disable iff (rst)
        (stop_trig && running) |=> (s_q.st == IPIC_IDLE) [*2])
        else $error("stop not honoured");
    AST_UNIT_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.unit_en && !wr) |=> (s_q.mode == MODE_RESET && s_q.cap == COUNT_RESET))
        else $error("unit not reset while disabled");
    COV_START:   cover property (@(posedge clk_sys) disable iff (rst) start_trig && !running);
    COV_PIN_CAP: cover property (@(posedge clk_sys) disable iff (rst) capture && pin_edge);
    COV_SW_CAP:  cover property (@(posedge clk_sys) disable iff (rst) capture && start_trig);
    COV_WRAP:    cover property (@(posedge clk_sys) disable iff (rst) capture && s_q.wrap_seen);
endmodule : ipic_channel

// [shared/ipic_pkg.sv]
// constants, register map and state encodings of the input pulse interval capture channel
// assumes one clk_sys domain at 40 MHz and an apb master with 32-bit data
package ipic_pkg;
    localparam logic [7:0]  ADDR_START_TRIG  = 8'h00;
    localparam logic [7:0]  ADDR_STOP_TRIG   = 8'h04;
    localparam logic [7:0]  ADDR_ENABLE_STAT = 8'h08;
    localparam logic [7:0]  ADDR_MODE_CFG    = 8'h0C;
    localparam logic [7:0]  ADDR_COUNTER     = 8'h10;
    localparam logic [7:0]  ADDR_CAPTURE     = 8'h14;
    localparam logic [7:0]  ADDR_STATUS      = 8'h18;
    localparam logic [7:0]  ADDR_UNIT_CTRL   = 8'h1C;
    // mode config field positions
    localparam int          MODE_START_IRQ   = 0;
    localparam int          MODE_EDGE_LO     = 1;
    localparam int          MODE_EDGE_HI     = 2;
    localparam int          MODE_TRIG_LSB    = 3;
    localparam int          MODE_WIDTH       = 6;
    localparam int          STATUS_WRAP      = 0;
    localparam int          UNIT_CLK_EN      = 0;
    localparam int          FILTER_EN        = 1;
    localparam logic [5:0]  MODE_RESET       = 6'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
    localparam int          COUNT_DIV        = 1;
    typedef enum logic [1:0] {
        IPIC_IDLE  = 2'b00,
        IPIC_LOAD  = 2'b01,
        IPIC_COUNT = 2'b11
    } ipic_state_type;
endpackage : ipic_pkg

// [hw/ipic_edge_detect.sv]
// synchroniser and edge selector for the timer input pin
// assumes the pin is asynchronous to clk_sys; optional 3-sample noise filter
module ipic_edge_detect
    import ipic_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       pin,
    input  wire logic       filter_en,
    input  wire logic [1:0] edge_sel,
    output logic            valid_edge
);
    typedef struct packed {
        logic [1:0] sync;
        logic [1:0] hist;
        logic       level;
        logic       edge_p;
    } ipic_edge_type;

    ipic_edge_type s_q;
    ipic_edge_type s_d;
    logic          flt;
    logic          rise;
    logic          fall;

    always_comb begin
        s_d      = s_q;
        s_d.sync = {s_q.sync[0], pin};
        s_d.hist = {s_q.hist[0], s_q.sync[1]};
        // filter trades two cycles of latency for glitch rejection
        flt      = filter_en ? ((s_q.hist == {2{s_q.sync[1]}}) ? s_q.sync[1] : s_q.level)
                             : s_q.sync[1];
        s_d.level = flt;
        rise     = flt & ~s_q.level;
        fall     = ~flt & s_q.level;
        case (edge_sel)
            2'b00:   s_d.edge_p = fall;
            2'b01:   s_d.edge_p = rise;
            default: s_d.edge_p = rise | fall;
        endcase
        if (clr) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign valid_edge = s_q.edge_p;
endmodule : ipic_edge_detect

// [sim/ipic_pulse_src.sv]
// pulse source model driving the timer input pin
// assumes clk_sys from the bench; pin holds its level while idle
module ipic_pulse_src (
    input  wire logic        clk_sys,
    input  wire logic        run,
    input  wire logic [15:0] hi_len,
    input  wire logic [15:0] lo_len,
    output logic             pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    initial begin
        pin = 1'b0;
        cnt_q = 16'h0000;
    end
    // a real pin keeps its level between bursts, so no idle pattern
    always @(posedge clk_sys) begin
        if (!run) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'h0000) begin
            pin <= ~pin;
            cnt_q <= (pin ? lo_len : hi_len) - 16'h0001;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule : ipic_pulse_src

// [sim/tb.sv]
// self-checking bench for the pulse interval capture channel
// assumes apb answers with one wait state and a 40 MHz clk_sys
module tb import ipic_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0]  es;
        logic [15:0] hi;
        logic [15:0] lo;
        logic [31:0] cap;
    } ipic_row_type;
    ipic_row_type rows [4] = '{'{2'h1, 16'h000a, 16'h000e, 32'h0000_0017},
        '{2'h0, 16'h0014, 16'h0005, 32'h0000_0018}, '{2'h2, 16'h0009, 16'h0009, 32'h0000_0008},
        '{2'h3, 16'h0006, 16'h0006, 32'h0000_0005}};
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, pin, irq, run, err;
    logic [7:0]  paddr;
    logic [15:0] hi_len, lo_len;
    logic [31:0] pwdata, prdata, rd, rd2, irq_cnt, c;
    int          bad_count, check_count, cyc;
    ipic_channel dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin(pin), .channel_interrupt(irq));
    ipic_pulse_src src (.clk_sys(clk_sys), .run(run), .hi_len(hi_len), .lo_len(lo_len),
        .pin(pin));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // pulses counted here, apb tasks would miss one during their own cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (rst) irq_cnt <= 32'h0000_0000;
        else if (irq === 1'b1) irq_cnt <= irq_cnt + 32'h0000_0001;
        if (cyc == 80000) begin
            bad_count++;
            $display("ERROR %0t run did not finish", $time);
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // one wait state: pready seen at the second access edge
        chk(n, 32'h0000_0002);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk
    task automatic irq_after(input logic [31:0] exp);
        repeat (5) @(posedge clk_sys);
        chk(irq_cnt, exp);
    endtask : irq_after
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, psel, penable, pwrite, run} = 5'h1f & 5'h10;
        {paddr, pwdata, hi_len, lo_len} = '0;
        {bad_count, check_count, cyc} = '0;
        repeat (6) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0000_0000);
        rst <= 1'b0;
        apb(1'b1, ADDR_MODE_CFG, 32'h0000_000a);
        rdchk(ADDR_MODE_CFG, 32'h0000_0000);
        apb(1'b1, ADDR_UNIT_CTRL, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            // later rows run with the noise filter on, set before the mode
            if (i == 2) apb(1'b1, ADDR_UNIT_CTRL, 32'h0000_0003);
            apb(1'b1, ADDR_MODE_CFG, {26'h0, 3'h1, rows[i].es, 1'b0});
            c = irq_cnt;
            apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
            irq_after(c);
            rdchk(ADDR_ENABLE_STAT, 32'h0000_0001);
            hi_len <= rows[i].hi;
            lo_len <= rows[i].lo;
            run <= 1'b1;
            for (int n = 0; n < 300 && irq_cnt < c + 3; n++) @(posedge clk_sys);
            rdchk(ADDR_CAPTURE, rows[i].cap);
            rdchk(ADDR_STATUS, 32'h0000_0000);
            run <= 1'b0;
            apb(1'b1, ADDR_STOP_TRIG, 32'h0000_0001);
            rdchk(ADDR_ENABLE_STAT, 32'h0000_0000);
        end
        // long period: one wrap, then software captures
        apb(1'b1, ADDR_MODE_CFG, 32'h0000_000b);
        c = irq_cnt;
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        irq_after(c + 1);
        apb(1'b1, ADDR_MODE_CFG, 32'h0000_003f);
        rdchk(ADDR_MODE_CFG, 32'h0000_000f);
        repeat (66000) @(posedge clk_sys);
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        rdchk(ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, ADDR_STOP_TRIG, 32'h0000_0001);
        rdchk(ADDR_STATUS, 32'h0000_0001);
        rdchk(ADDR_STOP_TRIG, 32'h0000_0000);
        apb(1'b0, ADDR_COUNTER, 32'h0000_0000);
        rd2 = rd;
        rdchk(ADDR_COUNTER, rd2);
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        rdchk(ADDR_CAPTURE, 32'h0000_0003);
        rdchk(ADDR_STATUS, 32'h0000_0000);
        apb(1'b1, ADDR_UNIT_CTRL, 32'h0000_0000);
        rdchk(ADDR_CAPTURE, 32'h0000_0000);
        rdchk(ADDR_UNIT_CTRL, 32'h0000_0000);
        rdchk(ADDR_ENABLE_STAT, 32'h0000_0000);
        apb(1'b1, ADDR_START_TRIG, 32'h0000_0001);
        rdchk(ADDR_ENABLE_STAT, 32'h0000_0000);
        rdchk(8'h20, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        print_verdict();
    end
endmodule : tb
